// File: rtl/fpes_sequencer.sv
// Purpose: Flash command decoder and automatic program/erase algorithm.
// Assumes: Array modelled as a register array of half-words, sectors by upper address bits.
// Notes:   Status replaces array data while the algorithm runs.
`include "fpes_consts.svh"
// Behaviour
// - Program runs alone after full sequence.
// - Programmed address reads inverted bit seven.
// - Host re-reads polling flag after limit; fpes_host re-reads the toggle flag instead.
// - Host re-checks toggle after limit flag.
// - Host programs one half-word per sequence.
// - Commands ignored while programming.
// - Reset mid-program leaves word undefined.
// - Host writes 32 bits as two halves.
// - Whole-array erase erases all sectors.
// - Chip erase reads status, bit seven done.
// - Chip erase time then back to read.
// - Several sectors queue into one erase.
// - Wait 35 us window before erasing.
// - Extra erase codes only inside window.
// - Sector erase reads status everywhere.
// - Host may detect end by toggle.
// - Host writes six-cycle sector erase sequence.
// - Host sets access size around sequences; fpes_host leaves this to software.
// - Host fails erase if toggle persists.
// - Host issues reset after limit failure.
// - Window flag zero while codes accepted.
// - Toggle flag alternates on status reads.
// - Limit flag set past rated pulse count.
module fpes_sequencer #(
  parameter int AW         = 8,
  parameter int SECT_BITS  = 2,
  parameter int PROG_CYC   = 40,
  parameter int ERASE_CYC  = 20,
  parameter int PRE_CYC    = 30,
  parameter int LIMIT_CYC  = 200,
  parameter int WIN_CYC    = `FPES_WIN_CYC
) (
  // Clock and reset.
  input  wire logic    clk_sys_in,
  input  wire logic    rst_in,
  // Command and read bus.
  fpes_link_if.seq     link,
  // Status of the automatic algorithm.
  output logic         busy_out,
  output logic         limit_out
);
  import fpes_pkg::*;
  localparam int NSECT = 1 << SECT_BITS;
  localparam int DEPTH = 1 << AW;

  typedef enum logic [2:0] {
    FPES_IDLE, FPES_U1, FPES_U2, FPES_E0, FPES_E1, FPES_E2, FPES_P
  } fpes_cseq_e;
  typedef enum logic [2:0] {
    FPES_READ, FPES_PROG, FPES_CHIP, FPES_WIN, FPES_ERASE
  } fpes_run_e;
  typedef struct packed {
    fpes_cseq_e       cseq;
    fpes_run_e        run;
    logic [AW-1:0]    paddr;
    logic [15:0]      pdata;
    logic [NSECT-1:0] sel;
    logic [15:0]      cnt;
    logic [15:0]      elapsed;
    logic             toggle;
    logic             toggle2;
    logic             limit;
    logic [15:0]      rdata;
    logic             rvalid;
    logic             busy;
  } fpes_state_s;

  fpes_state_s   s_q, s_d;
  logic [15:0]   mem [DEPTH];
  logic          mem_wr;
  logic          mem_erase;
  logic [AW-1:0] a;
  logic [7:0]    code;
  logic [AW-1:0] unlk1;
  logic [AW-1:0] unlk2;

  assign a    = link.addr[AW-1:0];
  assign code = link.wdata[7:0];
  // Unlock addresses keep only the bits this array decodes; the upper ones are don't-care.
  assign unlk1 = AW'(`FPES_ADDR_UNLK1);
  assign unlk2 = AW'(`FPES_ADDR_UNLK2);

  // Command decode, algorithm timing and status reads.
  always_comb begin
    s_d       = s_q;
    mem_wr    = 1'b0;
    mem_erase = 1'b0;
    s_d.rvalid = link.rd;
    if (s_q.run != FPES_READ && s_q.run != FPES_WIN) begin
      s_d.elapsed = s_q.elapsed + 16'h0001;
      if (s_q.elapsed >= 16'(LIMIT_CYC)) begin
        s_d.limit = 1'b1;
      end
    end
    // Status reads; the array location is never accessed while running.
    if (link.rd) begin
      if (s_q.run == FPES_READ) begin
        s_d.rdata = mem[a];
      end else begin
        s_d.toggle = ~s_q.toggle;
        s_d.rdata  = 16'h0000;
        s_d.rdata[`FPES_BIT_TOGGLE] = s_q.toggle;
        s_d.rdata[`FPES_BIT_TLIMIT] = s_q.limit;
        if (s_q.run == FPES_PROG) begin
          s_d.rdata[`FPES_BIT_POLL]   = ~s_q.pdata[`FPES_BIT_POLL];
          s_d.rdata[`FPES_BIT_WINDOW] = 1'b1;
        end else begin
          s_d.toggle2 = ~s_q.toggle2;
          s_d.rdata[`FPES_BIT_TOGGLE2] = s_q.toggle2;
          s_d.rdata[`FPES_BIT_POLL]    = 1'b0;
          s_d.rdata[`FPES_BIT_WINDOW]  = (s_q.run != FPES_WIN);
        end
      end
    end
    // Automatic algorithm, no outside control needed once started.
    unique case (s_q.run)
      FPES_READ: begin
      end
      FPES_PROG: begin
        s_d.cnt = s_q.cnt - 16'h0001;
        if (s_q.cnt == 16'h0000) begin
          mem_wr  = 1'b1;
          s_d.run = FPES_READ;
        end
      end
      FPES_WIN: begin
        s_d.cnt = s_q.cnt - 16'h0001;
        if (s_q.cnt == 16'h0000) begin
          s_d.run = FPES_ERASE;
          s_d.cnt = 16'(ERASE_CYC * NSECT);
        end
      end
      FPES_CHIP, FPES_ERASE: begin
        s_d.cnt = s_q.cnt - 16'h0001;
        if (s_q.cnt == 16'h0000) begin
          mem_erase = 1'b1;
          s_d.run   = FPES_READ;
        end
      end
      default: s_d.run = FPES_READ;
    endcase
    // Command sequence decoder; ignored while an algorithm runs, except sector codes inside the erase window.
    if (link.wr && s_q.run == FPES_WIN && code == `FPES_CODE_SECT) begin
      s_d.sel[a[AW-1 -: SECT_BITS]] = 1'b1;
    end else if (link.wr && s_q.run == FPES_READ) begin
      s_d.cseq = FPES_IDLE;
      unique case (s_q.cseq)
        FPES_IDLE:
          if (a == unlk1 && code == `FPES_CODE_UNLK1) s_d.cseq = FPES_U1;
        FPES_U1:
          if (a == unlk2 && code == `FPES_CODE_UNLK2) s_d.cseq = FPES_U2;
        FPES_U2:
          if (code == `FPES_CODE_PROG) s_d.cseq = FPES_P;
          else if (code == `FPES_CODE_ERASE) s_d.cseq = FPES_E0;
        FPES_E0:
          if (a == unlk1 && code == `FPES_CODE_UNLK1) s_d.cseq = FPES_E1;
        FPES_E1:
          if (a == unlk2 && code == `FPES_CODE_UNLK2) s_d.cseq = FPES_E2;
        FPES_E2: begin
          s_d.elapsed = 16'h0000;
          s_d.limit   = 1'b0;
          if (code == `FPES_CODE_CHIP) begin
            s_d.run = FPES_CHIP;
            s_d.sel = '1;
            s_d.cnt = 16'(ERASE_CYC * NSECT + PRE_CYC);
          end else if (code == `FPES_CODE_SECT) begin
            s_d.run = FPES_WIN;
            s_d.sel = '0;
            s_d.sel[a[AW-1 -: SECT_BITS]] = 1'b1;
            s_d.cnt = 16'(WIN_CYC - 1);
          end
        end
        FPES_P: begin
          s_d.run     = FPES_PROG;
          s_d.paddr   = a;
          s_d.pdata   = link.wdata;
          s_d.cnt     = 16'(PROG_CYC);
          s_d.elapsed = 16'h0000;
          s_d.limit   = 1'b0;
        end
        default: s_d.cseq = FPES_IDLE;
      endcase
    end
    s_d.busy = (s_d.run != FPES_READ);
  end

  // State register; a reset mid-program abandons the word being written.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '{cseq: FPES_IDLE, run: FPES_READ, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Array storage; programming only clears bits, as flash cells do.
  always_ff @(posedge clk_sys_in) begin
    if (mem_wr) begin
      mem[s_q.paddr] <= mem[s_q.paddr] & s_q.pdata;
    end
    if (mem_erase) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (s_q.sel[i >> (AW - SECT_BITS)]) begin
          mem[i] <= 16'hFFFF;
        end
      end
    end
  end

  assign link.rdata  = s_q.rdata;
  assign link.rvalid = s_q.rvalid;
  assign busy_out    = s_q.busy;
  assign limit_out   = s_q.limit;
endmodule

// File: pkg/fpes_consts.svh
// Purpose: Named constants of the flash program/erase sequencer.
// Assumes: 10 MHz system clock, half-word command bus.
// Notes:   Times are given in their own unit; cycle counts derive from them.
`ifndef FPES_CONSTS_SVH
`define FPES_CONSTS_SVH
`define FPES_CLK_MHZ        10
`define FPES_WIN_US         35
`define FPES_WIN_CYC        (`FPES_WIN_US * `FPES_CLK_MHZ)
`define FPES_ADDR_UNLK1     12'hAA8
`define FPES_ADDR_UNLK2     12'h554
`define FPES_CODE_UNLK1     8'hAA
`define FPES_CODE_UNLK2     8'h55
`define FPES_CODE_ERASE     8'h80
`define FPES_CODE_PROG      8'hA0
`define FPES_CODE_CHIP      8'h10
`define FPES_CODE_SECT      8'h30
`define FPES_CODE_RESET     8'hF0
`define FPES_BIT_POLL       7
`define FPES_BIT_TOGGLE     6
`define FPES_BIT_TLIMIT     5
`define FPES_BIT_WINDOW     3
`define FPES_BIT_TOGGLE2    2
`endif

// File: pkg/fpes_pkg.sv
// Purpose: Types shared by both ends of the flash sequencer link.
// Assumes: Nothing beyond the constants header.
// Notes:   Command kinds are the payload of the host's request port.
package fpes_pkg;
  typedef enum logic [1:0] {
    FPES_CMD_PROG,
    FPES_CMD_CHIP,
    FPES_CMD_SECT,
    FPES_CMD_RESET
  } fpes_cmd_e;
endpackage

// File: pkg/fpes_link_if.sv
// Purpose: Bus between command master and flash sequencer.
// Assumes: One write or read per cycle, answered the next cycle.
// Notes:   Read data is registered in the sequencer.
interface fpes_link_if #(parameter int AW = 20);
  logic          wr;
  logic          rd;
  logic [AW-1:0] addr;
  logic [15:0]   wdata;
  logic [15:0]   rdata;
  logic          rvalid;
  modport seq  (input wr, rd, addr, wdata, output rdata, rvalid);
  modport host (output wr, rd, addr, wdata, input rdata, rvalid);
endinterface

// File: rtl/fpes_host.sv
// Purpose: Command master issuing program and erase sequences and polling.
// Assumes: Sequencer answers reads one cycle later.
// Notes:   Access size register handling is outside this block.
`include "fpes_consts.svh"
module fpes_host #(
  parameter int AW = 8
) (
  // Clock and reset.
  input  wire logic                clk_sys_in,
  input  wire logic                rst_in,
  // User request.
  input  wire logic                req_in,
  input  wire fpes_pkg::fpes_cmd_e cmd_in,
  input  wire logic [AW-1:0]       addr_in,
  input  wire logic [15:0]         data_in,
  // User answer.
  output logic                     done_out,
  output logic                     fail_out,
  output logic                     ready_out,
  // Link to sequencer.
  fpes_link_if.host                link
);
  import fpes_pkg::*;
  typedef enum logic [2:0] {
    FPES_H_IDLE, FPES_H_SEQ, FPES_H_RD, FPES_H_WAIT, FPES_H_RESET
  } fpes_hst_e;
  typedef struct packed {
    fpes_hst_e     st;
    fpes_cmd_e     cmd;
    logic [2:0]    step;
    logic [AW-1:0] addr;
    logic [15:0]   data;
    logic          have;
    logic          prev_tog;
    logic          limit_seen;
    logic          wr;
    logic          rd;
    logic [AW-1:0] waddr;
    logic [15:0]   wdata;
    logic          done;
    logic          fail;
    logic          ready;
  } fpes_hst_s;
  fpes_hst_s h_q, h_d;
  logic [2:0] last;

  // One command sequence per half-word; a 32-bit unit is two requests.
  always_comb begin
    h_d      = h_q;
    h_d.wr   = 1'b0;
    h_d.rd   = 1'b0;
    h_d.done = 1'b0;
    h_d.fail = 1'b0;
    last     = (h_q.cmd == FPES_CMD_PROG) ? 3'd3 : 3'd5;
    unique case (h_q.st)
      FPES_H_IDLE:
        if (req_in) begin
          h_d.cmd  = cmd_in;
          h_d.addr = addr_in;
          h_d.data = data_in;
          h_d.step = 3'd0;
          h_d.have = 1'b0;
          h_d.limit_seen = 1'b0;
          h_d.st   = (cmd_in == FPES_CMD_RESET) ? FPES_H_RESET : FPES_H_SEQ;
        end
      FPES_H_SEQ: begin
        // Unlock cycles, then the command byte.
        h_d.wr = 1'b1;
        h_d.waddr = AW'(((h_q.step == 3'd1) || (h_q.step == 3'd4)) ? `FPES_ADDR_UNLK2 : `FPES_ADDR_UNLK1);
        h_d.wdata = ((h_q.step == 3'd1) || (h_q.step == 3'd4)) ? 16'(`FPES_CODE_UNLK2) : 16'(`FPES_CODE_UNLK1);
        if (h_q.step == 3'd2) begin
          h_d.wdata = (h_q.cmd == FPES_CMD_PROG) ? 16'(`FPES_CODE_PROG) : 16'(`FPES_CODE_ERASE);
        end
        if (h_q.step == last) begin
          h_d.waddr = h_q.addr;
          h_d.wdata = (h_q.cmd == FPES_CMD_PROG) ? h_q.data :
                      (h_q.cmd == FPES_CMD_CHIP) ? 16'(`FPES_CODE_CHIP) : 16'(`FPES_CODE_SECT);
          h_d.st = FPES_H_RD;
        end
        h_d.step = h_q.step + 3'd1;
      end
      FPES_H_RD: begin
        h_d.rd    = 1'b1;
        h_d.waddr = h_q.addr;
        h_d.st    = FPES_H_WAIT;
      end
      FPES_H_WAIT:
        if (link.rvalid) begin
          h_d.st = FPES_H_RD;
          h_d.have = 1'b1;
          h_d.prev_tog = link.rdata[`FPES_BIT_TOGGLE];
          // Toggle unchanged between two reads means the algorithm ended.
          if (h_q.have && link.rdata[`FPES_BIT_TOGGLE] == h_q.prev_tog) begin
            h_d.done = 1'b1;
            h_d.st   = FPES_H_IDLE;
          end else if (h_q.limit_seen && h_q.have) begin
            // Two reads after the limit still differ, so the algorithm is stuck.
            h_d.st = FPES_H_RESET;
          end else if (link.rdata[`FPES_BIT_TLIMIT] && !h_q.limit_seen) begin
            h_d.limit_seen = 1'b1;
            h_d.have       = 1'b0;
          end
        end
      FPES_H_RESET: begin
        h_d.wr    = 1'b1;
        h_d.waddr = AW'(`FPES_ADDR_UNLK1);
        h_d.wdata = 16'(`FPES_CODE_RESET);
        h_d.fail  = h_q.limit_seen;
        h_d.done  = ~h_q.limit_seen;
        h_d.st    = FPES_H_IDLE;
      end
      default: h_d.st = FPES_H_IDLE;
    endcase
    // Ready is registered so the output comes straight from a flip-flop.
    h_d.ready = (h_d.st == FPES_H_IDLE);
  end

  // Register; the access size field handling stays with software.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      h_q <= '{st: FPES_H_IDLE, cmd: FPES_CMD_PROG, ready: 1'b1, default: '0};
    end else begin
      h_q <= h_d;
    end
  end

  assign link.wr    = h_q.wr;
  assign link.rd    = h_q.rd;
  assign link.addr  = h_q.waddr;
  assign link.wdata = h_q.wdata;
  assign done_out   = h_q.done;
  assign fail_out   = h_q.fail;
  assign ready_out  = h_q.ready;
endmodule

// File: tb/fpes_link_monitor.sv
// Purpose: Concurrent checks on the link between host and sequencer.
// Assumes: Status replaces array data when the sequencer was busy as the read was taken.
// Notes:   Helper flags keep the last program data bit and the last toggle value read.
`include "fpes_consts.svh"
module fpes_link_monitor (
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Link signals.
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid,
  // Sequencer status.
  input  wire logic        busy_out,
  input  wire logic        limit_out
);
  logic bsy_rd_q, lim_rd_q, arm_q, prog_q, d7_q, tog_q, seen_q;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Track what each status read must show; a read taken idle ends a toggle run.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      {bsy_rd_q, lim_rd_q, arm_q, prog_q, d7_q, tog_q, seen_q} <= '0;
    end else begin
      if (rd) begin
        bsy_rd_q <= busy_out;
        lim_rd_q <= limit_out;
      end
      if (wr && arm_q) begin
        arm_q  <= 1'b0;
        prog_q <= 1'b1;
        d7_q   <= wdata[7];
      end else if (wr) begin
        arm_q <= (wdata[7:0] == `FPES_CODE_PROG);
        if (wdata[7:0] == `FPES_CODE_ERASE) begin
          prog_q <= 1'b0;
        end
      end
      if (rvalid) begin
        seen_q <= bsy_rd_q;
        tog_q  <= rdata[6];
      end
    end
  end
  property p_rvalid_follows; rd |=> rvalid; endproperty
  a_rvalid_follows: assert property (p_rvalid_follows) else $error("read not answered");
  property p_rvalid_only; !rd |=> !rvalid; endproperty
  a_rvalid_only: assert property (p_rvalid_only) else $error("answer without read");
  property p_rdata_hold; !rvalid |-> $stable(rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_toggle_alt; rvalid && bsy_rd_q && seen_q |-> rdata[6] != tog_q; endproperty
  a_toggle_alt: assert property (p_toggle_alt) else $error("toggle flag stuck");
  property p_poll_bit;
    rvalid && bsy_rd_q |-> rdata[`FPES_BIT_POLL] == (prog_q ? !d7_q : 1'b0);
  endproperty
  a_poll_bit: assert property (p_poll_bit) else $error("polling flag wrong");
  property p_limit_bit; rvalid && bsy_rd_q |-> rdata[`FPES_BIT_TLIMIT] == lim_rd_q; endproperty
  a_limit_bit: assert property (p_limit_bit) else $error("limit flag wrong");
  property p_window_bit; rvalid && bsy_rd_q && prog_q |-> rdata[`FPES_BIT_WINDOW]; endproperty
  a_window_bit: assert property (p_window_bit) else $error("window flag low in program");
  property p_busy_min; $rose(busy_out) |-> busy_out [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("algorithm stopped early");
  property p_limit_busy; $rose(limit_out) |-> busy_out; endproperty
  a_limit_busy: assert property (p_limit_busy) else $error("limit without algorithm");
  // Main scenarios seen at least once.
  c_busy: cover property ($rose(busy_out));
  c_limit: cover property ($rose(limit_out));
  c_toggle: cover property (rvalid && bsy_rd_q && seen_q);
endmodule

// File: tb/fpes_sequencer_tb.sv
// Purpose: Self-checking bench for host and sequencer joined by their link.
// Assumes: The host ends each completed program or erase with a read whose data stays on the link.
// Notes:   The limit is set below a chip erase time, so a chip erase must fail.
module fpes_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fpes_pkg::*;
  logic        clk_sys_in, rst_in, req, done, fail, ready, busy, limit;
  fpes_cmd_e   cmd;
  logic [7:0]  addr, a0;
  logic [15:0] data, w0, w1;
  int          miscompares, tests_run;
  logic [17:0] exp_q[$];
  fpes_link_if #(.AW(8)) fpes_link_if_i ();
  // Limit lies between one sector erase (81 cycles) and a chip erase (111 cycles).
  fpes_sequencer #(.LIMIT_CYC(85), .WIN_CYC(20)) fpes_sequencer_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .link(fpes_link_if_i.seq), .busy_out(busy), .limit_out(limit));
  fpes_host fpes_host_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req), .cmd_in(cmd),
    .addr_in(addr), .data_in(data), .done_out(done), .fail_out(fail), .ready_out(ready),
    .link(fpes_link_if_i.host));
  fpes_link_monitor fpes_link_monitor_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wr(fpes_link_if_i.wr),
    .rd(fpes_link_if_i.rd), .wdata(fpes_link_if_i.wdata), .rdata(fpes_link_if_i.rdata),
    .rvalid(fpes_link_if_i.rvalid), .busy_out(busy), .limit_out(limit));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Issue one command; an aborted one is cut by reset once the algorithm runs.
  task automatic run(input fpes_cmd_e c, input logic [7:0] a, input logic [15:0] d, input logic f,
                     input logic [15:0] e, input logic chk, input logic abort);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge clk_sys_in);
      n++;
    end
    check("ready", 16'h1, {15'h0, ready});
    if (!abort) begin
      exp_q.push_back({chk, f, e});
    end
    req  = 1'b1;
    cmd  = c;
    addr = a;
    data = d;
    @(negedge clk_sys_in);
    req = 1'b0;
    n   = 0;
    while (!(abort ? busy === 1'b1 : (done === 1'b1 || fail === 1'b1)) && n < 3000) begin
      @(negedge clk_sys_in);
      n++;
    end
    check("command end", 16'h0, 16'(n == 3000));
    if (abort) begin
      repeat (5) @(negedge clk_sys_in);
      rst_in = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      rst_in = 1'b0;
    end
    @(negedge clk_sys_in);
  endtask
  // Each completion takes the oldest note; settled values are read at the falling edge.
  always @(negedge clk_sys_in) begin
    if (done === 1'b1 || fail === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("result count", 16'h0, 16'h1);
      end else begin
        logic [17:0] n;
        n = exp_q.pop_front();
        check("fail flag", {15'h0, n[16]}, {15'h0, fail});
        if (n[17]) begin
          check("read data", n[15:0], fpes_link_if_i.rdata);
        end
      end
    end
  end
  // Free-running system clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  // A whole run needs under two thousand cycles; stop well beyond that.
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    miscompares++;
    $display("Error watchdog expected end seen timeout");
    give_verdict();
  end
  initial begin
    {req, addr, data} = '0;
    cmd = FPES_CMD_PROG;
    rst_in = 1'b1;
    void'($urandom(32'hD3FC));
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    for (int s = 0; s < 4; s++) run(FPES_CMD_SECT, 8'(s * 64 + 5), 16'h0, 0, 16'hFFFF, 1, 0);
    $display("test sector erase done");
    for (int k = 0; k < 3; k++) begin
      w0 = 16'($urandom());
      w1 = 16'($urandom());
      a0 = {2'(k), 6'($urandom())} & 8'hFE;
      run(FPES_CMD_PROG, a0 | 8'h01, w1, 0, w1, 1, 0);
      run(FPES_CMD_PROG, a0, w0, 0, w0, 1, 0);
    end
    run(FPES_CMD_PROG, a0, w0 & w1, 0, w0 & w1, 1, 0);
    $display("test program done");
    run(FPES_CMD_CHIP, 8'h10, 16'h0, 1, 16'h0, 0, 0);
    // The stuck erase still runs to its end; a sequence sent meanwhile would be ignored.
    while (busy === 1'b1) begin
      @(negedge clk_sys_in);
    end
    run(FPES_CMD_SECT, a0, 16'h0, 0, 16'hFFFF, 1, 0);
    $display("test limit failure done");
    run(FPES_CMD_PROG, a0, w1, 0, w1, 0, 1);
    exp_q.delete();
    run(FPES_CMD_SECT, a0, 16'h0, 0, 16'hFFFF, 1, 0);
    run(FPES_CMD_PROG, a0, w1, 0, w1, 1, 0);
    $display("test reset in program done");
    run(FPES_CMD_RESET, 8'h00, 16'h0, 0, 16'h0, 0, 0);
    $display("test reset command done");
    give_verdict();
  end
endmodule
